// ==== mtc_client.sv ====
// Purpose: Client model feeding transmit frames into the transmitter
// Assumes: Beats are queued by the bench, one byte per entry
// Notes: An offered byte is held until it is taken
`timescale 1ns/1ps

module mtc_client (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SLOW,
  input wire logic S_TREADY,
  output logic [7:0] S_TDATA,
  output logic S_TLAST,
  output logic S_TVALID
);
  mtc_pkg::mtc_beat_t q[$];
  logic hold_r;
  logic taken;

  initial
  begin
    S_TVALID = 1'b0;
    S_TLAST = 1'b0;
    S_TDATA = 8'h00;
    hold_r = 1'b0;
  end

  // Pops a beat when taken, then offers the next; with SLOW every other offer slot stays idle
  always @(posedge CLOCK)
  begin
    taken = S_TVALID && S_TREADY && RST_N;
    if (taken)
      void'(q.pop_front());
    #1;
    if (taken || !S_TVALID)
    begin
      hold_r = SLOW && !hold_r;
      if (q.size() > 0 && !hold_r)
      begin
        S_TVALID = 1'b1;
        {S_TLAST, S_TDATA} = q[0];
      end
      else
      begin
        S_TVALID = 1'b0;
        S_TLAST = 1'b0;
        S_TDATA = ~S_TDATA;
      end
    end
  end
endmodule : mtc_client

// ==== mtc_defines.svh ====
// Purpose: Constants of the transmitter configuration word and its datapath
// Assumes: Byte-wide transmit path, one byte per clock
// Notes: Definitions only
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH

// Bit positions of the configuration word
`define MTC_B_RST 31
`define MTC_B_JUMBO 30
`define MTC_B_FCS_IN 29
`define MTC_B_TX_EN 28
`define MTC_B_VLAN 27
`define MTC_B_WAN 26
`define MTC_B_ADJ 25
`define MTC_B_DIC 24
`define MTC_B_KEEP_PRE 23
`define MTC_B_CMD_INL 22

// Reset value, only bit 28 set
`define MTC_CFG_DEF 32'h1000_0000

// Frame sizes in bytes, FCS included except in the minimum data length
`define MTC_MAX_STD 16'h05EE
`define MTC_MAX_VLAN 16'h05F2
`define MTC_MIN_DATA 16'h003C
`define MTC_FCS_LEN 16'h0004

// Gap and WAN stretch
`define MTC_MIN_IFG 8'h0C
`define MTC_WAN_DIV 4'hC

// Line symbols
`define MTC_PRE 8'h55
`define MTC_SFD 8'hD5
`define MTC_TPID_HI 8'h81
`define MTC_TPID_LO 8'h00
`define MTC_CRC_POLY 32'hEDB8_8320
`define MTC_CRC_INIT 32'hFFFF_FFFF
`define MTC_PRE_LAST 3'h7

// Client FIFO
`define MTC_FIFO_DEPTH 8

`endif

// ==== mtc_pkg.sv ====
// Purpose: Types shared by the transmitter configuration block
// Assumes: Constants live in mtc_defines.svh
// Notes: No imports are used anywhere
package mtc_pkg;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } mtc_beat_t;

  typedef struct packed {
    logic jumbo;
    logic fcs_in;
    logic tx_en;
    logic vlan;
    logic wan;
    logic adj;
    logic dic;
    logic keep_pre;
    logic cmd_inl;
  } mtc_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_CPRE, ST_PRE, ST_DATA, ST_DROP, ST_PAD, ST_FCS, ST_IFG
  } mtc_state_t;

endpackage : mtc_pkg

// ==== mtc_tx_config.sv ====
// Purpose: Transmitter configuration word and the byte transmitter it steers
// Assumes: Client bytes and config writes synchronous to CLOCK
// Notes: One byte per clock on the line side
// How it works
// - Writing bit 31 resets transmitter and config; bit self-clears.
// - Bit 30 allows frames above legal maximum; otherwise longer frames cut at the limit with error, rest dropped.
// - Bit 29 set: client supplies FCS, transmitter forwards it.
// - Bit 29 clear: pad short frames, compute and append FCS.
// - Bit 28, default one, enables the transmitter.
// - Bit 27 set: VLAN frames allowed, limit 1522 bytes.
// - Bit 27 clear: VLAN frames not counted, limit 1518 bytes.
// - Bit 26 set: extra idles stretch gaps to WAN rate.
// - Bit 25 set: gap delay input sampled at frame start lengthens gap.
// - Bit 25 clear: delay input ignored; lane-aligned minimum gap emitted.
// - Gap adjust ignored while WAN mode selected.
// - Bit 24 set: deficit idle count shortens gaps.
// - Bit 24 clear: gap stretched to keep starts lane aligned.
// - Gap adjust enabled forces deficit idle bit clear.
// - Bit 23 set: client preamble sent; clear: standard preamble.
// - Bit 22 selects in-line or out-of-band command field.
// - Bit 23 overrides bit 22.
`timescale 1ns/1ps
`include "mtc_defines.svh"

module mtc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic rdy_r;
  wire push = in_valid & rdy_r;
  wire pop = out_ready & out_valid;
  wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready = rdy_r;
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end
    else
    begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      rdy_r <= cnt_nxt != (AW+1)'(DEPTH);
    end
  end
endmodule : mtc_fifo

module mtc_tx_config (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CFG_WE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  input wire logic [7:0] S_TDATA,
  input wire logic S_TLAST,
  input wire logic S_TVALID,
  output logic S_TREADY,
  input wire logic [7:0] IFG_DELAY,
  input wire logic [7:0] TS_CMD_OOB,
  output logic [7:0] TS_CMD,
  output logic TS_CMD_VALID,
  output logic [7:0] M_TXD,
  output logic M_TXEN,
  output logic M_TXERR,
  output logic [15:0] FRAME_COUNT
);
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `MTC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  mtc_pkg::mtc_cfg_t cfg_r;
  mtc_pkg::mtc_cfg_t cfg_wr;
  mtc_pkg::mtc_cfg_t cfg_def;
  mtc_pkg::mtc_state_t st_r;
  mtc_pkg::mtc_state_t st_nxt;
  mtc_pkg::mtc_beat_t f_beat;
  logic soft_r;
  logic f_valid;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic tag_r;
  logic tag_nxt;
  logic [7:0] txd_nxt;
  logic txen_nxt;
  logic err_nxt;
  logic ifg_load;
  logic [1:0] tot_r;
  logic [1:0] dic_r;
  logic [3:0] wdiv_r;
  logic [7:0] wext_r;
  logic [7:0] dly_r;
  logic [7:0] ifg_r;

  wire clr = ~RST_N | soft_r;
  wire rst_wr = CFG_WE & CFG_WDATA[`MTC_B_RST];
  wire [31:0] def_w = `MTC_CFG_DEF;
  assign cfg_def = def_w[`MTC_B_JUMBO:`MTC_B_CMD_INL];
  assign cfg_wr.jumbo = CFG_WDATA[`MTC_B_JUMBO];
  assign cfg_wr.fcs_in = CFG_WDATA[`MTC_B_FCS_IN];
  assign cfg_wr.tx_en = CFG_WDATA[`MTC_B_TX_EN];
  assign cfg_wr.vlan = CFG_WDATA[`MTC_B_VLAN];
  assign cfg_wr.wan = CFG_WDATA[`MTC_B_WAN];
  assign cfg_wr.adj = CFG_WDATA[`MTC_B_ADJ];
  assign cfg_wr.dic = CFG_WDATA[`MTC_B_DIC] & ~CFG_WDATA[`MTC_B_ADJ];
  assign cfg_wr.keep_pre = CFG_WDATA[`MTC_B_KEEP_PRE];
  assign cfg_wr.cmd_inl = CFG_WDATA[`MTC_B_CMD_INL];

  // Decode of the datapath
  wire start = (st_r == mtc_pkg::ST_IDLE) & cfg_r.tx_en & f_valid;
  wire pop = f_valid & ((st_r == mtc_pkg::ST_CMD) | (st_r == mtc_pkg::ST_CPRE)
    | (st_r == mtc_pkg::ST_DATA) | (st_r == mtc_pkg::ST_DROP));
  wire [15:0] cnt_inc = cnt_r + 16'h0001;
  wire [15:0] len_now = cnt_inc + (cfg_r.fcs_in ? 16'h0000 : `MTC_FCS_LEN);
  wire [15:0] limit = (cfg_r.vlan & tag_r) ? `MTC_MAX_VLAN : `MTC_MAX_STD;
  wire too_long = ~cfg_r.jumbo & (len_now > limit);
  wire [31:0] fcs_sh = ~crc_r >> {idx_r[1:0], 3'b000};
  wire [7:0] pre_byte = (idx_r == `MTC_PRE_LAST) ? `MTC_SFD : `MTC_PRE;

  // Gap length from lane phase, deficit, adjust and WAN stretch
  wire adj_eff = cfg_r.adj & ~cfg_r.wan;
  wire [1:0] ph = tot_r + 2'(txen_nxt);
  wire [1:0] ext = 2'(2'h0 - ph);
  wire [2:0] dic_sum = {1'b0, dic_r} + {1'b0, ph};
  wire shrink = cfg_r.dic & (ph != 2'h0) & (dic_sum <= 3'h3);
  wire [7:0] ifg_align = shrink ? `MTC_MIN_IFG - {6'h00, ph} : `MTC_MIN_IFG + {6'h00, ext};
  wire [7:0] ifg_adj = (dly_r > `MTC_MIN_IFG) ? dly_r : `MTC_MIN_IFG;
  wire [7:0] ifg_gap = adj_eff ? ifg_adj : ifg_align;
  wire [7:0] ifg_len = cfg_r.wan ? 8'(ifg_gap + wext_r) : ifg_gap;
  wire [1:0] dic_nxt = shrink ? dic_sum[1:0] : ((dic_r > ext) ? 2'(dic_r - ext) : 2'h0);
  wire count_ok = ifg_load & (st_r != mtc_pkg::ST_DROP) & ~err_nxt
    & ~(tag_r & ~cfg_r.vlan);

  mtc_fifo #(
    .WIDTH($bits(mtc_pkg::mtc_beat_t)),
    .DEPTH(`MTC_FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .clr(clr),
    .in_data({S_TLAST, S_TDATA}),
    .in_valid(S_TVALID),
    .in_ready(S_TREADY),
    .out_data(f_beat),
    .out_valid(f_valid),
    .out_ready(pop)
  );

  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    crc_nxt = crc_r;
    tag_nxt = tag_r;
    txd_nxt = 8'h00;
    txen_nxt = 1'b0;
    err_nxt = 1'b0;
    ifg_load = 1'b0;
    case (st_r)
      mtc_pkg::ST_IDLE:
        if (start)
        begin
          cnt_nxt = 16'h0000;
          crc_nxt = `MTC_CRC_INIT;
          tag_nxt = 1'b0;
          idx_nxt = 3'h0;
          if (cfg_r.keep_pre)
            st_nxt = mtc_pkg::ST_CPRE;
          else if (cfg_r.cmd_inl)
            st_nxt = mtc_pkg::ST_CMD;
          else
            st_nxt = mtc_pkg::ST_PRE;
        end
      mtc_pkg::ST_CMD:
        if (f_valid)
          st_nxt = mtc_pkg::ST_PRE;
      mtc_pkg::ST_CPRE:
        if (f_valid)
        begin
          txd_nxt = f_beat.data;
          txen_nxt = 1'b1;
          idx_nxt = idx_r + 3'h1;
          if (idx_r == `MTC_PRE_LAST)
            st_nxt = mtc_pkg::ST_DATA;
        end
      mtc_pkg::ST_PRE:
      begin
        txd_nxt = pre_byte;
        txen_nxt = 1'b1;
        idx_nxt = idx_r + 3'h1;
        if (idx_r == `MTC_PRE_LAST)
          st_nxt = mtc_pkg::ST_DATA;
      end
      mtc_pkg::ST_DATA:
        if (f_valid)
        begin
          cnt_nxt = cnt_inc;
          if (cnt_r == 16'h000C)
            tag_nxt = f_beat.data == `MTC_TPID_HI;
          if (cnt_r == 16'h000D)
            tag_nxt = tag_r & (f_beat.data == `MTC_TPID_LO);
          if (too_long)
          begin
            err_nxt = 1'b1;
            if (f_beat.last)
            begin
              ifg_load = 1'b1;
              st_nxt = mtc_pkg::ST_IFG;
            end
            else
              st_nxt = mtc_pkg::ST_DROP;
          end
          else
          begin
            txd_nxt = f_beat.data;
            txen_nxt = 1'b1;
            crc_nxt = crc_byte(crc_r, f_beat.data);
            idx_nxt = 3'h0;
            if (f_beat.last & cfg_r.fcs_in)
            begin
              ifg_load = 1'b1;
              st_nxt = mtc_pkg::ST_IFG;
            end
            else if (f_beat.last)
              st_nxt = (cnt_inc < `MTC_MIN_DATA) ? mtc_pkg::ST_PAD : mtc_pkg::ST_FCS;
          end
        end
      mtc_pkg::ST_DROP:
        if (f_valid & f_beat.last)
        begin
          ifg_load = 1'b1;
          st_nxt = mtc_pkg::ST_IFG;
        end
      mtc_pkg::ST_PAD:
      begin
        txen_nxt = 1'b1;
        cnt_nxt = cnt_inc;
        crc_nxt = crc_byte(crc_r, 8'h00);
        if (cnt_inc == `MTC_MIN_DATA)
          st_nxt = mtc_pkg::ST_FCS;
      end
      mtc_pkg::ST_FCS:
      begin
        txd_nxt = fcs_sh[7:0];
        txen_nxt = 1'b1;
        idx_nxt = idx_r + 3'h1;
        if (idx_r == 3'h3)
        begin
          ifg_load = 1'b1;
          st_nxt = mtc_pkg::ST_IFG;
        end
      end
      mtc_pkg::ST_IFG:
        if (ifg_r == 8'h00)
          st_nxt = mtc_pkg::ST_IDLE;
      default:
        st_nxt = mtc_pkg::ST_IDLE;
    endcase
  end

  // Configuration word and self-clearing reset
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N | rst_wr)
      cfg_r <= cfg_def;
    else if (CFG_WE)
      cfg_r <= cfg_wr;
    soft_r <= RST_N & rst_wr;
    CFG_RDATA <= !RST_N ? 32'h0000_0000 : {soft_r, cfg_r, 22'h00_0000};
  end

  always_ff @(posedge CLOCK)
  begin
    if (clr)
    begin
      st_r <= mtc_pkg::ST_IDLE;
      idx_r <= 3'h0;
      cnt_r <= 16'h0000;
      crc_r <= `MTC_CRC_INIT;
      tag_r <= 1'b0;
      M_TXD <= 8'h00;
      M_TXEN <= 1'b0;
      M_TXERR <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      crc_r <= crc_nxt;
      tag_r <= tag_nxt;
      M_TXD <= txd_nxt;
      M_TXEN <= txen_nxt;
      M_TXERR <= err_nxt;
    end
  end

  // Gap, deficit and WAN stretch state
  always_ff @(posedge CLOCK)
  begin
    if (clr | start)
      tot_r <= 2'h0;
    else
      tot_r <= tot_r + 2'(txen_nxt);
    if (clr)
      dic_r <= 2'h0;
    else if (ifg_load)
      dic_r <= cfg_r.dic ? dic_nxt : 2'h0;
    if (clr | ifg_load)
    begin
      wdiv_r <= 4'h0;
      wext_r <= 8'h00;
    end
    else if (txen_nxt)
    begin
      wdiv_r <= (wdiv_r == `MTC_WAN_DIV) ? 4'h0 : wdiv_r + 4'h1;
      if (wdiv_r == `MTC_WAN_DIV)
        wext_r <= wext_r + 8'h01;
    end
    if (clr)
      ifg_r <= 8'h00;
    else if (ifg_load)
      ifg_r <= ifg_len - 8'h01;
    else if ((st_r == mtc_pkg::ST_IFG) & (ifg_r != 8'h00))
      ifg_r <= ifg_r - 8'h01;
  end

  // Command field, gap delay sample, statistics
  always_ff @(posedge CLOCK)
  begin
    if (clr)
    begin
      TS_CMD <= 8'h00;
      TS_CMD_VALID <= 1'b0;
      dly_r <= 8'h00;
      FRAME_COUNT <= 16'h0000;
    end
    else
    begin
      if (start)
        dly_r <= IFG_DELAY;
      if (start & (cfg_r.keep_pre | ~cfg_r.cmd_inl))
        TS_CMD <= TS_CMD_OOB;
      else if ((st_r == mtc_pkg::ST_CMD) & f_valid)
        TS_CMD <= f_beat.data;
      TS_CMD_VALID <= (start & (cfg_r.keep_pre | ~cfg_r.cmd_inl))
        | ((st_r == mtc_pkg::ST_CMD) & f_valid);
      if (count_ok)
        FRAME_COUNT <= FRAME_COUNT + 16'h0001;
    end
  end

  sequence s_fcs_run;
    (st_r == mtc_pkg::ST_FCS) [*4] ##1 (st_r == mtc_pkg::ST_IFG);
  endsequence

  sequence s_soft_done;
    soft_r ##1 (!soft_r && CFG_RDATA[`MTC_B_RST]) ##1 !CFG_RDATA[`MTC_B_RST];
  endsequence

  AST_SOFT_RST: assert property (@(posedge CLOCK) disable iff (!RST_N)
    rst_wr |=> (cfg_r == cfg_def) ##0 s_soft_done)
    else $error("Transmitter reset did not restore defaults");
  AST_JUMBO_OK: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (st_r == mtc_pkg::ST_DATA && f_valid && cfg_r.jumbo) |=> !M_TXERR && M_TXEN)
    else $error("Jumbo byte was refused");
  AST_FCS_FWD: assert property (@(posedge CLOCK) disable iff (clr)
    (st_r == mtc_pkg::ST_DATA && f_valid && f_beat.last && cfg_r.fcs_in && !too_long)
    |=> st_r == mtc_pkg::ST_IFG)
    else $error("FCS appended in pass-through mode");
  AST_FCS_ADD: assert property (@(posedge CLOCK) disable iff (clr)
    (st_r == mtc_pkg::ST_DATA && f_valid && f_beat.last && !cfg_r.fcs_in && !too_long
    && cnt_r >= 16'h003B) |=> s_fcs_run)
    else $error("FCS not appended");
  AST_TX_OFF: assert property (@(posedge CLOCK) disable iff (clr)
    (st_r == mtc_pkg::ST_IDLE && !cfg_r.tx_en) |=> st_r == mtc_pkg::ST_IDLE)
    else $error("Frame started while disabled");
  AST_VLAN_MAX: assert property (@(posedge CLOCK) disable iff (clr)
    (st_r == mtc_pkg::ST_DATA && f_valid && cfg_r.vlan && tag_r && len_now <= 16'h05F2)
    |=> !M_TXERR)
    else $error("Tagged frame cut below 1522 bytes");
  AST_NO_COUNT: assert property (@(posedge CLOCK) disable iff (clr)
    (ifg_load && tag_r && !cfg_r.vlan) |=> FRAME_COUNT == $past(FRAME_COUNT))
    else $error("Tagged frame counted with VLAN off");
  AST_WAN_GAP: assert property (@(posedge CLOCK) disable iff (clr)
    (ifg_load && cfg_r.wan && wext_r > 8'h02) |=> ifg_r > 8'h0A)
    else $error("WAN gap not stretched");
  AST_MIN_GAP: assert property (@(posedge CLOCK) disable iff (clr)
    (ifg_load && !cfg_r.adj && !cfg_r.dic && !cfg_r.wan) |=> ifg_r >= 8'h0B && ifg_r <= 8'h0E)
    else $error("Gap outside minimum aligned range");
  AST_DIC_FORCE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (CFG_WE && CFG_WDATA[`MTC_B_ADJ] && !rst_wr) |=> !cfg_r.dic)
    else $error("Deficit idle bit kept with gap adjust");
  AST_PRESERVE: assert property (@(posedge CLOCK) disable iff (clr)
    (start && cfg_r.keep_pre) |=> st_r == mtc_pkg::ST_CPRE && TS_CMD_VALID
    && TS_CMD == $past(TS_CMD_OOB))
    else $error("Preamble preserve not taking precedence");
  AST_RSVD: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CFG_RDATA[21:0] == 22'h00_0000)
    else $error("Reserved bits read nonzero");

endmodule : mtc_tx_config

// ==== tb.sv ====
// Purpose: Self-checking bench of the transmitter configuration word
// Assumes: Client model in mtc_client.sv, config on the direct write port
// Notes: Gaps are checked as bounds, frames byte by byte
`timescale 1ns/1ps
`include "mtc_defines.svh"

module tb;
  typedef struct { logic [31:0] wd; logic [31:0] rd; } mtc_row_t;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic CFG_WE = 1'b0;
  logic [31:0] CFG_WDATA = 32'h0000_0000;
  logic [7:0] IFG_DELAY = 8'h00;
  logic [7:0] TS_CMD_OOB = 8'h00;
  logic SLOW = 1'b0;
  logic [31:0] CFG_RDATA;
  logic [7:0] S_TDATA, TS_CMD, M_TXD;
  logic S_TLAST, S_TVALID, S_TREADY, TS_CMD_VALID, M_TXEN, M_TXERR;
  logic [15:0] FRAME_COUNT, fc;
  logic [7:0] rx[$], exp[$], frm[$];
  logic [7:0] ts_got = 8'h00;
  logic seen = 1'b0;
  logic prev_en = 1'b0;
  int gaps[$];
  int g[5];
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int idle_cnt = 0;
  int errs = 0;
  mtc_row_t rows[4] = '{'{32'h7FFF_FFFF, 32'h7EC0_0000}, '{32'h013F_FFFF, 32'h0100_0000},
    '{32'h0300_0000, 32'h0200_0000}, '{32'h003F_FFFF, 32'h0000_0000}};

  always #10 CLOCK = ~CLOCK;

  mtc_tx_config u_mtc_tx_config (.CLOCK(CLOCK), .RST_N(RST_N), .CFG_WE(CFG_WE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .S_TDATA(S_TDATA), .S_TLAST(S_TLAST),
    .S_TVALID(S_TVALID), .S_TREADY(S_TREADY), .IFG_DELAY(IFG_DELAY),
    .TS_CMD_OOB(TS_CMD_OOB), .TS_CMD(TS_CMD), .TS_CMD_VALID(TS_CMD_VALID), .M_TXD(M_TXD),
    .M_TXEN(M_TXEN), .M_TXERR(M_TXERR), .FRAME_COUNT(FRAME_COUNT));

  mtc_client u_mtc_client (.CLOCK(CLOCK), .RST_N(RST_N), .SLOW(SLOW), .S_TREADY(S_TREADY),
    .S_TDATA(S_TDATA), .S_TLAST(S_TLAST), .S_TVALID(S_TVALID));

  // Line monitor
  always @(posedge CLOCK)
  begin
    cycles++;
    if (M_TXEN)
    begin
      if (!prev_en && seen)
        gaps.push_back(idle_cnt);
      seen = 1'b1;
      idle_cnt = 0;
      rx.push_back(M_TXD);
    end
    else
      idle_cnt++;
    prev_en = M_TXEN;
    if (M_TXERR)
      errs++;
    if (TS_CMD_VALID)
      ts_got = TS_CMD;
    if (cycles == 40000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want)
    begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, want);
    end
  endtask : cmp

  task automatic wr(input logic [31:0] d);
    CFG_WE = 1'b1;
    CFG_WDATA = d;
    @(posedge CLOCK);
    #1;
    CFG_WE = 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask : wr

  task automatic mk(input int n, input bit tg);
    frm.delete();
    for (int i = 0; i < n; i++)
      frm.push_back(8'(i * 29 + 7));
    if (tg)
    begin
      frm[12] = `MTC_TPID_HI;
      frm[13] = `MTC_TPID_LO;
    end
  endtask : mk

  task automatic add_fcs();
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    while (frm.size() < 60)
      frm.push_back(8'h00);
    foreach (frm[i])
    begin
      c = c ^ {24'h00_0000, frm[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
    end
    c = ~c;
    for (int k = 0; k < 4; k++)
      frm.push_back(c[8 * k +: 8]);
  endtask : add_fcs

  task automatic push();
    rx.delete();
    foreach (frm[i])
      u_mtc_client.q.push_back({i == frm.size() - 1, frm[i]});
  endtask : push

  task automatic wait_idle();
    while (u_mtc_client.q.size() > 0 || idle_cnt < 60)
    begin
      @(posedge CLOCK);
      #1;
    end
  endtask : wait_idle

  task automatic send();
    push();
    wait_idle();
  endtask : send

  task automatic chk_line(input bit std, input int skip);
    exp.delete();
    if (std)
    begin
      repeat (7) exp.push_back(`MTC_PRE);
      exp.push_back(`MTC_SFD);
    end
    for (int i = skip; i < frm.size(); i++)
      exp.push_back(frm[i]);
    cmp(32'(rx.size()), 32'(exp.size()));
    foreach (exp[i])
    begin
      if (i < rx.size() && rx[i] !== exp[i])
      begin
        cmp(32'(rx[i]), 32'(exp[i]));
        break;
      end
    end
  endtask : chk_line

  task automatic gap(input logic [31:0] c, input logic [7:0] d, output int r);
    wr(c);
    IFG_DELAY = d;
    mk(65, 1'b0);
    gaps.delete();
    seen = 1'b0;
    push();
    push();
    wait_idle();
    r = (gaps.size() > 0) ? gaps[0] : -1;
  endtask : gap

  initial
  begin
    repeat (2) @(posedge CLOCK);
    #1;
    RST_N = 1'b1;
    @(posedge CLOCK);
    #1;
    cmp(CFG_RDATA, `MTC_CFG_DEF);
    cmp(32'({S_TREADY, M_TXEN, M_TXERR}), 32'h0000_0004);
    foreach (rows[i])
    begin
      wr(rows[i].wd);
      cmp(CFG_RDATA, rows[i].rd);
    end
    wr(32'h7EC0_0000);
    wr(32'h8000_0000);
    repeat (2) @(posedge CLOCK);
    #1;
    cmp(CFG_RDATA, `MTC_CFG_DEF);
    SLOW = 1'b1;
    TS_CMD_OOB = 8'h5A;
    fc = FRAME_COUNT;
    mk(10, 1'b0);
    send();
    SLOW = 1'b0;
    add_fcs();
    chk_line(1'b1, 0);
    cmp(32'(ts_got), 32'h0000_005A);
    cmp(32'(FRAME_COUNT), 32'(fc + 16'h0001));
    mk(61, 1'b0);
    send();
    add_fcs();
    chk_line(1'b1, 0);
    wr(32'h3000_0000);
    mk(60, 1'b0);
    add_fcs();
    send();
    chk_line(1'b1, 0);
    wr(32'h30C0_0000);
    TS_CMD_OOB = 8'h3C;
    mk(60, 1'b0);
    add_fcs();
    for (int i = 0; i < 8; i++)
      frm.push_front(8'hA0 + 8'(i));
    send();
    chk_line(1'b0, 0);
    cmp(32'(ts_got), 32'h0000_003C);
    wr(32'h3040_0000);
    mk(60, 1'b0);
    add_fcs();
    frm.push_front(8'hC3);
    send();
    chk_line(1'b1, 1);
    cmp(32'(ts_got), 32'h0000_00C3);
    gap(32'h3000_0000, 8'h28, g[0]);
    cmp(32'(g[0] >= 12 && g[0] < 40), 32'h1);
    gap(32'h3200_0000, 8'h28, g[1]);
    cmp(32'(g[1] >= 40), 32'h1);
    gap(32'h3600_0000, 8'h28, g[2]);
    cmp(32'(g[2] >= 0 && g[2] < 40), 32'h1);
    gap(32'h3400_0000, 8'h28, g[3]);
    cmp(32'(g[3] > g[0]), 32'h1);
    gap(32'h3100_0000, 8'h28, g[4]);
    cmp(32'(g[4] >= 0 && g[4] <= g[0]), 32'h1);
    wr(32'h3000_0000);
    fc = FRAME_COUNT;
    errs = 0;
    mk(1519, 1'b0);
    send();
    cmp(32'(rx.size()), 32'h0000_05F6);
    cmp(32'(errs), 32'h1);
    cmp(32'(FRAME_COUNT), 32'(fc));
    wr(32'h7000_0000);
    send();
    cmp(32'(rx.size()), 32'h0000_05F7);
    wr(32'h3800_0000);
    fc = FRAME_COUNT;
    mk(1522, 1'b1);
    send();
    cmp(32'(rx.size()), 32'h0000_05FA);
    cmp(32'(FRAME_COUNT), 32'(fc + 16'h0001));
    wr(32'h3000_0000);
    mk(70, 1'b1);
    send();
    cmp(32'(rx.size()), 32'h0000_004E);
    cmp(32'(FRAME_COUNT), 32'(fc + 16'h0001));
    wr(32'h2000_0000);
    mk(64, 1'b0);
    push();
    repeat (30) @(posedge CLOCK);
    #1;
    cmp(32'({S_TREADY, M_TXEN}), 32'h0);
    cmp(32'(u_mtc_client.q.size() inside {[55:56]}), 32'h1);
    wr(32'h3000_0000);
    wait_idle();
    cmp(32'(rx.size()), 32'h0000_0048);
    complete_run();
  end
endmodule : tb
